// [src/sefc_params.svh]
// Offsets, field positions, reset values and codes of the event/queue/format block.
// Included by the threshold and core design files; definitions only.
`ifndef SEFC_PARAMS_SVH
`define SEFC_PARAMS_SVH

`define SEFC_OFS_DATA 3'h0
`define SEFC_OFS_EVENT 3'h2
`define SEFC_OFS_FORMAT 3'h3
`define SEFC_OFS_MODE 3'h4
`define SEFC_OFS_EXT 3'h7

`define SEFC_ID_NONE 4'h1
`define SEFC_ID_LINE 4'h6
`define SEFC_ID_RXLVL 4'h4
`define SEFC_ID_RXTO 4'hc
`define SEFC_ID_TXLOW 4'h2
`define SEFC_ID_MODEM 4'h0

`define SEFC_FMT_RESET 8'h00
`define SEFC_BANK_RESET 8'h00
`define SEFC_QCTL_RESET 8'h00
`define SEFC_MODE_RESET 3'h0

`define SEFC_B_QEN 0
`define SEFC_B_RECEIVER_SOFT_RESET 1
`define SEFC_B_TRANSMITTER_SOFT_RESET 2
`define SEFC_B_BANK_SELECT_ENABLE 7
`define SEFC_B_STB 2
`define SEFC_B_PEN 3
`define SEFC_B_EPS 4
`define SEFC_B_CONSTANT_PARITY 5
`define SEFC_B_BRK 6
`define SEFC_B_EXTSEL 0
`define SEFC_B_IRMS 1
`define SEFC_B_MODEMOD 2

`define SEFC_MODE_SERIAL 3'h0
`define SEFC_MODE_ASK 3'h2
`define SEFC_MODE_SIR 3'h3
`define SEFC_MODE_CIR 3'h6

`define SEFC_TO_CHARS 4'h4

`endif

// [src/sefc_pkg.sv]
// Types shared by the event/queue/format block files.
// Assumes sefc_params.svh is included alongside.
package sefc_pkg;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sefc_bus_t;

	typedef struct packed {
		logic [5:0] len;
		logic [1:0] rx_thr_sel;
		logic [1:0] tx_thr_sel;
		logic deep32;
	} sefc_level_t;

	typedef struct packed {
		logic [1:0] bits;
		logic two_stop;
		logic half_stop;
		logic par_en;
		logic par_even;
		logic par_stick;
		logic brk;
	} sefc_format_t;

	typedef enum logic [2:0] {
		SEFC_ID_IDLE = 3'b001,
		SEFC_ID_HOLD = 3'b010,
		SEFC_ID_DONE = 3'b100
	} sefc_idst_t;

endpackage

// [src/sefc_thresh.sv]
// Queue threshold compare for the receive and transmit queues.
// Assumes fill counts come from the same clock domain.
`timescale 1ns/1ps
`include "sefc_params.svh"

module sefc_thresh (
	input wire logic [1:0] rx_sel,
	input wire logic [1:0] tx_sel,
	input wire logic deep32,
	input wire logic [5:0] rx_fill,
	input wire logic [5:0] tx_fill,
	output logic rx_high,
	output logic tx_low
);

	function automatic logic [5:0] rx_thr(input logic [1:0] s, input logic d);
		case (s)
			2'h0: rx_thr = 6'h01;
			2'h1: rx_thr = d ? 6'h08 : 6'h04;
			2'h2: rx_thr = d ? 6'h10 : 6'h08;
			default: rx_thr = d ? 6'h1a : 6'h0e;
		endcase
	endfunction

	function automatic logic [5:0] tx_thr(input logic [1:0] s, input logic d);
		case (s)
			2'h0: tx_thr = 6'h01;
			2'h1: tx_thr = d ? 6'h07 : 6'h03;
			2'h2: tx_thr = d ? 6'h11 : 6'h09;
			default: tx_thr = d ? 6'h19 : 6'h0d;
		endcase
	endfunction

	always_comb begin
		rx_high = rx_fill >= rx_thr(rx_sel, deep32); // see [R17]
		tx_low = tx_fill < tx_thr(tx_sel, deep32); // see [R16]
	end

endmodule

// [src/sefc_core.sv]
// Event identification, queue control and character format control.
// Assumes a host register port on clk and line/queue status from same-domain logic,
// except the modem pins, which are synchronised here.
//
// Notes on behaviour
// [R01] Legacy id 0001 idle, 0110 line status
// [R02] 0100 receive level, 1100 receive timeout
// [R03] 0010 transmit empty, cleared by write/id read
// [R04] 0000 modem input change, cleared by status read
// [R05] Displayed code frozen during identification read
// [R06] Bit0 low when pending; bits7:6 queues enabled
// [R07] Extended bits set regardless of enables
// [R08] Bit4 terminal count, cleared by id read
// [R09] Bit0 receive level, bit1 transmit level
// [R10] Bit2 line errors; queued errors at bottom
// [R11] Consumer infrared: bit2 overrun or underrun
// [R12] Bit3 modem event, masked by infrared select
// [R13] Bit5 mirrors transmitter idle status, held low in SIR mode
// [R14] Control bit0 enables queues, clear empties
// [R15] Bits1,2 self-clearing receiver/transmitter soft resets
// [R16] Transmit threshold select, below threshold event
// [R17] Receive threshold select, at/above threshold event
// [R18] Offset 3 reads bank, write bit7 steering
// [R19] Character length 5 to 8 bits
// [R20] Stop bits 1, 1.5 or 2
// [R21] Parity none, odd, even, mark, space
// [R22] Break forces transmit front end
// [R23] Bank-1 codes also write format register
// [R24] Mode change empties queues, clears status events
`timescale 1ns/1ps
`include "sefc_params.svh"

module sefc_core (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic rx_write,
	input wire logic rx_read,
	input wire logic [5:0] rx_fill,
	input wire logic [5:0] tx_fill,
	input wire logic deep32,
	input wire logic char_tick,
	input wire logic err_overrun,
	input wire logic err_bottom,
	input wire logic tx_underrun,
	input wire logic tx_idle,
	input wire logic dma_tc,
	input wire logic lsr_read,
	input wire logic msr_read,
	input wire logic [3:0] modem_pins,
	input wire logic ser_data,
	input wire logic ir_pulse,
	output logic [7:0] modem_status,
	output logic queues_enabled,
	output logic rx_soft_reset,
	output logic tx_soft_reset,
	output sefc_pkg::sefc_format_t format,
	output logic serial_output,
	output logic infrared_output
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] fmt_q, fmt_d;
	logic [7:0] bank_q, bank_d;
	logic [7:0] qctl_q, qctl_d;
	logic [2:0] mode_q, mode_d;
	logic ext_q, ext_d, irms_q, irms_d, mod_q, mod_d;
	logic receiver_soft_reset_q, receiver_soft_reset_d, transmitter_soft_reset_q, transmitter_soft_reset_d;
	logic ls_q, ls_d, ms_q, ms_d, dma_q, dma_d, thre_q, thre_d, to_q, to_d;
	logic [3:0] tocnt_q, tocnt_d;
	logic [3:0] msync1_q, msync2_q, mprev_q;
	logic [3:0] mdelta_q, mdelta_d;
	logic [3:0] shown_q, shown_d;
	logic [7:0] rdata_q, rdata_d;
	logic txne_q, txne_d;
	sefc_pkg::sefc_idst_t st_q, st_d;

	logic wr_ev, rd_ev, wr_fmt, wr_mode, wr_ext, rd_id, wr_tx, rd_rx;
	logic cir, mode_chg, rx_high, tx_low, bank1, any_modem;
	logic [3:0] live_id;
	logic [7:0] ext_id, leg_id;

	always_comb begin
		wr_ev = reg_wr && reg_addr == `SEFC_OFS_EVENT;
		rd_ev = reg_rd && reg_addr == `SEFC_OFS_EVENT;
		wr_fmt = reg_wr && reg_addr == `SEFC_OFS_FORMAT;
		wr_mode = reg_wr && reg_addr == `SEFC_OFS_MODE;
		wr_ext = reg_wr && reg_addr == `SEFC_OFS_EXT;
		rd_id = rd_ev;
		wr_tx = reg_wr && reg_addr == `SEFC_OFS_DATA;
		rd_rx = rx_read || (reg_rd && reg_addr == `SEFC_OFS_DATA);
		cir = ext_q && mode_q == `SEFC_MODE_CIR;
		mode_chg = wr_mode && ext_q && reg_wdata[7:5] != mode_q;
		// Codes 1x..x1, 1x..1x or 10.. with bit7 set still name bank 1
		bank1 = reg_wdata[6] == 1'b0 || reg_wdata[1] || reg_wdata[0];
	end

	// ----------------------------------------
	// Modem pin synchroniser and change detect
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			msync1_q <= 4'h0;
			msync2_q <= 4'h0;
			mprev_q <= 4'h0;
		end else begin
			msync1_q <= modem_pins;
			msync2_q <= msync1_q;
			mprev_q <= msync2_q;
		end
	end

	always_comb begin
		// Pins: [0] clear-to-send, [1] data-set-ready, [2] ring, [3] carrier
		mdelta_d = mdelta_q;
		if (msr_read || mode_chg)
			mdelta_d = 4'h0;
		mdelta_d[0] = mdelta_d[0] | (msync2_q[0] ^ mprev_q[0]); // see [R04]
		mdelta_d[1] = mdelta_d[1] | (msync2_q[1] ^ mprev_q[1]);
		mdelta_d[2] = mdelta_d[2] | (msync2_q[2] & ~mprev_q[2]);
		mdelta_d[3] = mdelta_d[3] | (msync2_q[3] ^ mprev_q[3]);
		any_modem = |mdelta_q; // see [R12]
		modem_status = {msync2_q, mdelta_q};
	end

	// ----------------------------------------
	// Threshold compare
	// ----------------------------------------
	sefc_thresh u_thresh (
		.rx_sel(qctl_q[7:6]),
		.tx_sel(qctl_q[5:4]),
		.deep32(deep32),
		.rx_fill(rx_fill),
		.tx_fill(tx_fill),
		.rx_high(rx_high),
		.tx_low(tx_low)
	);

	// ----------------------------------------
	// Control and format writes
	// ----------------------------------------
	always_comb begin
		fmt_d = fmt_q;
		bank_d = bank_q;
		qctl_d = qctl_q;
		mode_d = mode_q;
		ext_d = ext_q;
		irms_d = irms_q;
		mod_d = mod_q;
		receiver_soft_reset_d = 1'b0; // see [R15]
		transmitter_soft_reset_d = 1'b0;
		if (wr_ev) begin
			qctl_d = reg_wdata;
			qctl_d[`SEFC_B_RECEIVER_SOFT_RESET] = 1'b0;
			qctl_d[`SEFC_B_TRANSMITTER_SOFT_RESET] = 1'b0;
			if (!ext_q)
				qctl_d[5:4] = 2'h0; // see [R16]
			if (cir)
				qctl_d[`SEFC_B_QEN] = 1'b1; // see [R14]
			receiver_soft_reset_d = reg_wdata[`SEFC_B_RECEIVER_SOFT_RESET]; // see [R15]
			transmitter_soft_reset_d = reg_wdata[`SEFC_B_TRANSMITTER_SOFT_RESET];
		end
		if (wr_fmt) begin
			bank_d = reg_wdata; // see [R18]
			if (!reg_wdata[`SEFC_B_BANK_SELECT_ENABLE] || bank1)
				fmt_d = reg_wdata; // see [R23]
		end
		if (wr_mode && ext_q)
			mode_d = reg_wdata[7:5]; // see [R24]
		if (wr_ext) begin
			ext_d = reg_wdata[`SEFC_B_EXTSEL];
			irms_d = reg_wdata[`SEFC_B_IRMS];
			mod_d = reg_wdata[`SEFC_B_MODEMOD];
		end
		if (cir)
			qctl_d[`SEFC_B_QEN] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fmt_q <= `SEFC_FMT_RESET;
			bank_q <= `SEFC_BANK_RESET;
			qctl_q <= `SEFC_QCTL_RESET;
			mode_q <= `SEFC_MODE_RESET;
			ext_q <= 1'b0;
			irms_q <= 1'b0;
			mod_q <= 1'b0;
			receiver_soft_reset_q <= 1'b0;
			transmitter_soft_reset_q <= 1'b0;
		end else begin
			fmt_q <= fmt_d;
			bank_q <= bank_d;
			qctl_q <= qctl_d;
			mode_q <= mode_d;
			ext_q <= ext_d;
			irms_q <= irms_d;
			mod_q <= mod_d;
			receiver_soft_reset_q <= receiver_soft_reset_d;
			transmitter_soft_reset_q <= transmitter_soft_reset_d;
		end
	end

	always_comb begin
		queues_enabled = qctl_q[`SEFC_B_QEN];
		// Clearing the enable and changing mode both empty the queues
		rx_soft_reset = receiver_soft_reset_q || (wr_ev && !reg_wdata[`SEFC_B_QEN] && !cir) || mode_chg; // see [R14]
		tx_soft_reset = transmitter_soft_reset_q || (wr_ev && !reg_wdata[`SEFC_B_QEN] && !cir) || mode_chg; // see [R24]
		format.bits = fmt_q[1:0]; // see [R19]
		format.two_stop = fmt_q[`SEFC_B_STB] && fmt_q[1:0] != 2'h0; // see [R20]
		format.half_stop = fmt_q[`SEFC_B_STB] && fmt_q[1:0] == 2'h0;
		format.par_en = fmt_q[`SEFC_B_PEN]; // see [R21]
		format.par_even = fmt_q[`SEFC_B_EPS];
		format.par_stick = fmt_q[`SEFC_B_CONSTANT_PARITY];
		format.brk = fmt_q[`SEFC_B_BRK];
		if (cir)
			format = '0; // see [R19]
	end

	// ----------------------------------------
	// Break on the transmit front end
	// ----------------------------------------
	always_comb begin
		serial_output = ser_data && !format.brk; // see [R22]
		infrared_output = ir_pulse;
		if (format.brk && ext_q && (mode_q == `SEFC_MODE_SIR || mode_q == `SEFC_MODE_ASK))
			infrared_output = (mode_q == `SEFC_MODE_ASK && !mod_q) ? 1'b1 : char_tick; // see [R22]
	end

	// ----------------------------------------
	// Event sources
	// ----------------------------------------
	always_comb begin
		// Set wins over clear on every sticky flag except the timeout, where clear wins
		ls_d = (ls_q && !lsr_read && !mode_chg && !receiver_soft_reset_q)
			|| err_overrun || (!cir && err_bottom) // see [R10]
			|| (cir && tx_underrun); // see [R11]
		ms_d = any_modem; // see [R04]
		dma_d = (dma_q && !rd_id) || dma_tc; // see [R08]
		thre_d = thre_q;
		if (wr_tx || (rd_id && st_q == sefc_pkg::SEFC_ID_IDLE && shown_q == `SEFC_ID_TXLOW))
			thre_d = 1'b0; // see [R03]
		// Set on the step into empty only, else an id read could never clear it
		txne_d = tx_fill != 6'h00;
		if (tx_fill == 6'h00 && txne_q)
			thre_d = 1'b1;
		// Timeout counts character times while data sit untouched
		tocnt_d = tocnt_q;
		to_d = to_q;
		if (rx_write || rd_rx || rx_fill == 6'h00 || !queues_enabled) begin
			tocnt_d = 4'h0;
			to_d = 1'b0; // see [R02]
		end else if (char_tick && tocnt_q != `SEFC_TO_CHARS) begin
			tocnt_d = tocnt_q + 4'h1;
			if (tocnt_q + 4'h1 == `SEFC_TO_CHARS)
				to_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ls_q <= 1'b0;
			ms_q <= 1'b0;
			dma_q <= 1'b0;
			thre_q <= 1'b0;
			to_q <= 1'b0;
			tocnt_q <= 4'h0;
			mdelta_q <= 4'h0;
			txne_q <= 1'b0;
		end else begin
			ls_q <= ls_d;
			ms_q <= ms_d;
			dma_q <= dma_d;
			thre_q <= thre_d;
			to_q <= to_d;
			tocnt_q <= tocnt_d;
			mdelta_q <= mdelta_d;
			txne_q <= txne_d;
		end
	end

	// ----------------------------------------
	// Identification encode and read freeze
	// ----------------------------------------
	always_comb begin
		if (ls_q)
			live_id = `SEFC_ID_LINE; // see [R01]
		else if (to_q)
			live_id = `SEFC_ID_RXTO; // see [R02]
		else if (rx_high)
			live_id = `SEFC_ID_RXLVL; // see [R02]
		else if (thre_q)
			live_id = `SEFC_ID_TXLOW; // see [R03]
		else if (ms_q)
			live_id = `SEFC_ID_MODEM; // see [R04]
		else
			live_id = `SEFC_ID_NONE; // see [R01]
		shown_d = live_id;
		st_d = sefc_pkg::SEFC_ID_IDLE;
		case (st_q)
			sefc_pkg::SEFC_ID_IDLE: begin
				if (rd_id)
					st_d = sefc_pkg::SEFC_ID_HOLD;
			end
			sefc_pkg::SEFC_ID_HOLD: begin
				shown_d = shown_q; // see [R05]
				st_d = rd_id ? sefc_pkg::SEFC_ID_HOLD : sefc_pkg::SEFC_ID_DONE;
			end
			sefc_pkg::SEFC_ID_DONE: st_d = sefc_pkg::SEFC_ID_IDLE;
			default: st_d = sefc_pkg::SEFC_ID_IDLE;
		endcase
		if (rd_id)
			shown_d = shown_q;
		leg_id = {{2{queues_enabled}}, 2'h0, shown_q}; // see [R06]
		ext_id = 8'h00;
		ext_id[0] = queues_enabled ? (rx_high || to_q) : (rx_fill != 6'h00); // see [R09]
		ext_id[1] = queues_enabled ? tx_low : (tx_fill == 6'h00); // see [R09]
		ext_id[2] = ls_q; // see [R07]
		ext_id[3] = ms_q && !(mode_q != `SEFC_MODE_SERIAL && irms_q); // see [R12]
		ext_id[4] = dma_q; // see [R08]
		ext_id[5] = tx_idle && mode_q != `SEFC_MODE_SIR; // see [R13]
		rdata_d = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`SEFC_OFS_EVENT: rdata_d = ext_q ? ext_id : leg_id;
				`SEFC_OFS_FORMAT: rdata_d = bank_q; // see [R18]
				`SEFC_OFS_MODE: rdata_d = {mode_q, 5'h00};
				`SEFC_OFS_EXT: rdata_d = {5'h00, mod_q, irms_q, ext_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shown_q <= `SEFC_ID_NONE;
			st_q <= sefc_pkg::SEFC_ID_IDLE;
			rdata_q <= 8'h00;
		end else begin
			shown_q <= shown_d;
			st_q <= st_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule

// [verification/sefc_core_chk.sv]
// Port checker for the event/queue/format block.
// Assumes one-cycle host strobes and read data in the cycle after the read.
`timescale 1ns/1ps
module sefc_core_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic msr_read,
	input wire logic [7:0] modem_status,
	input wire logic queues_enabled,
	input wire logic rx_soft_reset,
	input wire sefc_pkg::sefc_format_t format
);
	// ----
	// Shadow of bank select and extended select
	// ----
	logic [7:0] bank_q, bank_d;
	logic [2:0] mode_q, mode_d;
	logic ext_q, ext_d;
	logic w2, w3, cir;
	assign w2 = reg_wr && reg_addr == 3'h2;
	assign w3 = reg_wr && reg_addr == 3'h3;
	// Consumer infrared zeroes the format, so the format load checks step aside there; the bank-write hold check still runs
	assign cir = ext_q && mode_q == 3'h6;
	always_comb begin
		bank_d = w3 ? reg_wdata : bank_q;
		ext_d = (reg_wr && reg_addr == 3'h7) ? reg_wdata[0] : ext_q;
		mode_d = (reg_wr && reg_addr == 3'h4 && ext_q) ? reg_wdata[7:5] : mode_q;
	end
	always_ff @(posedge clk) begin
		bank_q <= sys_rst ? 8'h00 : bank_d;
		ext_q <= sys_rst ? 1'b0 : ext_d;
		mode_q <= sys_rst ? 3'h0 : mode_d;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ----
	// Assertions
	// ----
	id_code_a: assert property (reg_rd && reg_addr == 3'h2 && !ext_q |=>
		reg_rdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0} && reg_rdata[5:4] == 2'h0)
		else $error("illegal legacy identification code");
	id_qen_a: assert property (reg_rd && reg_addr == 3'h2 && !ext_q |=>
		reg_rdata[7:6] == {2{$past(queues_enabled)}}) else $error("queue flags wrong in id");
	ext_rsvd_a: assert property (reg_rd && reg_addr == 3'h2 && ext_q |=>
		reg_rdata[7:6] == 2'h0) else $error("extended id reserved bits set");
	bank_read_a: assert property (reg_rd && reg_addr == 3'h3 |=>
		reg_rdata == $past(bank_q)) else $error("offset 3 read is not bank select");
	fmt_write_a: assert property (w3 && !reg_wdata[7] && !cir |=>
		format.bits == $past(reg_wdata[1:0])
		&& format.par_en == $past(reg_wdata[3]) && format.par_even == $past(reg_wdata[4])
		&& format.par_stick == $past(reg_wdata[5]) && format.brk == $past(reg_wdata[6]))
		else $error("format not loaded");
	stop_bits_a: assert property (w3 && !reg_wdata[7] && !cir |=>
		format.half_stop == ($past(reg_wdata[2]) && $past(reg_wdata[1:0]) == 2'h0)
		&& format.two_stop == ($past(reg_wdata[2]) && $past(reg_wdata[1:0]) != 2'h0))
		else $error("stop bit setting wrong");
	fmt_hold_a: assert property (w3 && reg_wdata[7:6] == 2'h3 && reg_wdata[1:0] == 2'h0 |=>
		$stable(format)) else $error("format changed on bank write");
	bank1_write_a: assert property (w3 && reg_wdata[7:6] == 2'h2 && !cir |=>
		format.bits == $past(reg_wdata[1:0])) else $error("bank 1 code did not load format");
	qen_set_a: assert property (w2 && reg_wdata[0] |=> queues_enabled)
		else $error("queues not enabled");
	qen_fall_a: assert property ($fell(queues_enabled) |-> $past(w2))
		else $error("queues disabled without a control write");
	receiver_soft_reset_pulse_a: assert property (w2 && reg_wdata[1] |-> ##[0:1] rx_soft_reset)
		else $error("no receiver soft reset");
	receiver_soft_reset_clear_a: assert property (rx_soft_reset |-> ##[1:3] !rx_soft_reset)
		else $error("receiver soft reset stuck");
	msr_clear_a: assert property (msr_read && $stable(modem_status[7:4]) |=>
		modem_status[3:0] == 4'h0) else $error("modem deltas not cleared");
	bank_c: cover property (w3 && reg_wdata[7]);
	sr_c: cover property (rx_soft_reset);
	ext_c: cover property (reg_rd && reg_addr == 3'h2 && ext_q);
endmodule
bind sefc_core sefc_core_chk u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.msr_read(msr_read), .modem_status(modem_status), .queues_enabled(queues_enabled),
	.rx_soft_reset(rx_soft_reset), .format(format));

// [verification/sefc_line_model.sv]
// Line-side model: character timer and idle serial data.
// Assumes the bench gates it; the timer clears to zero while run is low.
`timescale 1ns/1ps
module sefc_line_model #(
	parameter int CHAR_CYC = 16
) (
	input wire logic clk,
	input wire logic run,
	output logic char_tick,
	output logic ser_data
);
	logic [7:0] cnt_q, cnt_d;
	always_comb begin
		cnt_d = (run && !char_tick) ? cnt_q + 8'h01 : 8'h00;
	end
	always_ff @(posedge clk) begin
		cnt_q <= cnt_d;
	end
	assign char_tick = run && cnt_q == 8'(CHAR_CYC - 1);
	// Mark level between characters, so break must come from the block
	assign ser_data = 1'b1;
endmodule

// [verification/test_serial_event_fifo_format_ctrl.sv]
// Directed bench for the event/queue/format block.
// Assumes the host port contract and the line model beside the block.
`timescale 1ns/1ps
module test_serial_event_fifo_format_ctrl;
	logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rx_read = 1'b0;
	logic err_overrun = 1'b0, err_bottom = 1'b0, tx_idle = 1'b1, dma_tc = 1'b0;
	logic lsr_read = 1'b0, msr_read = 1'b0, run = 1'b0, saw_rx = 1'b0, saw_tx = 1'b0;
	logic tx_underrun = 1'b0, deep32 = 1'b0, ir_out;
	logic [7:0] n_ir = 8'h00;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [5:0] rx_fill = 6'h00, tx_fill = 6'h01;
	logic [3:0] modem_pins = 4'h0;
	logic char_tick, ser_data, serial_output, queues_enabled, rx_soft_reset, tx_soft_reset;
	sefc_pkg::sefc_format_t format;
	int n_fail = 0;
	int num_checks = 0;
	always #2.5 clk = ~clk;
	sefc_line_model u_line (.clk(clk), .run(run), .char_tick(char_tick), .ser_data(ser_data));
	sefc_core DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_write(1'b0), .rx_read(rx_read),
		.rx_fill(rx_fill), .tx_fill(tx_fill), .deep32(deep32), .char_tick(char_tick),
		.err_overrun(err_overrun), .err_bottom(err_bottom), .tx_underrun(tx_underrun), .tx_idle(tx_idle),
		.dma_tc(dma_tc), .lsr_read(lsr_read), .msr_read(msr_read), .modem_pins(modem_pins),
		.ser_data(ser_data), .ir_pulse(1'b0), .modem_status(), .queues_enabled(queues_enabled),
		.rx_soft_reset(rx_soft_reset), .tx_soft_reset(tx_soft_reset), .format(format),
		.serial_output(serial_output), .infrared_output(ir_out));
	always @(posedge clk) begin
		if (rx_soft_reset === 1'b1) saw_rx <= 1'b1;
		if (tx_soft_reset === 1'b1) saw_tx <= 1'b1;
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic pulse(input logic l, input logic m, input logic d, input logic r);
		@(posedge clk);
		{lsr_read, msr_read, dma_tc, rx_read} <= {l, m, d, r};
		@(posedge clk);
		{lsr_read, msr_read, dma_tc, rx_read} <= 4'h0;
		tick(4);
	endtask
	function automatic logic [7:0] fmt_of(input logic [7:0] v);
		sefc_pkg::sefc_format_t f;
		f = {v[1:0], v[2] && v[1:0] != 2'h0, v[2] && v[1:0] == 2'h0, v[3], v[4], v[5], v[6]};
		return f;
	endfunction
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#50000;
		n_fail++;
		stop_test();
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(3'h2, 8'h01);
		rd(3'h3, 8'h00);
		chk(format, 8'h00);
		wr(3'h2, 8'h01);
		rd(3'h2, 8'hc1);
		@(posedge clk);
		{modem_pins, tx_fill, rx_fill, err_bottom} <= {4'h1, 6'h00, 6'h01, 1'b1};
		@(posedge clk);
		err_bottom <= 1'b0;
		tick(6);
		rd(3'h2, 8'hc6);
		pulse(1'b1, 1'b0, 1'b0, 1'b0);
		rd(3'h2, 8'hc4);
		rx_fill <= 6'h00;
		pulse(1'b0, 1'b0, 1'b0, 1'b1);
		rd(3'h2, 8'hc2);
		tx_fill <= 6'h01;
		tick(4);
		rd(3'h2, 8'hc0);
		pulse(1'b0, 1'b1, 1'b0, 1'b0);
		rd(3'h2, 8'hc1);
		$display("end priority");
		modem_pins <= 4'h0;
		tick(6);
		@(posedge clk);
		reg_addr <= 3'h2;
		reg_rd <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			err_overrun <= (i == 1);
			#1 chk(reg_rdata, 8'hc0);
		end
		@(posedge clk);
		reg_rd <= 1'b0;
		tick(4);
		rd(3'h2, 8'hc6);
		pulse(1'b1, 1'b1, 1'b0, 1'b0);
		$display("end freeze");
		wr(3'h2, 8'hc1);
		@(posedge clk);
		{rx_fill, run} <= {6'h01, 1'b1};
		tick(80);
		rd(3'h2, 8'hcc);
		{rx_fill, run} <= {6'h00, 1'b0};
		pulse(1'b0, 1'b0, 1'b0, 1'b1);
		rd(3'h2, 8'hc1);
		$display("end timeout");
		for (int i = 0; i < 64; i++) begin
			wr(3'h3, 8'(i));
			tick(1);
			chk(format, fmt_of(8'(i)));
		end
		wr(3'h3, 8'he0);
		tick(1);
		chk(format, fmt_of(8'h3f));
		rd(3'h3, 8'he0);
		wr(3'h3, 8'h83);
		tick(1);
		chk(format, fmt_of(8'h03));
		wr(3'h3, 8'h40);
		tick(1);
		chk({7'h0, serial_output}, 8'h00);
		wr(3'h3, 8'h00);
		tick(1);
		chk({7'h0, serial_output}, 8'h01);
		$display("end format");
		wr(3'h2, 8'h07);
		tick(3);
		chk({saw_rx, saw_tx, rx_soft_reset, tx_soft_reset}, 8'h0c);
		$display("end soft reset");
		wr(3'h7, 8'h01);
		wr(3'h2, 8'h51);
		{rx_fill, tx_fill} <= {6'h03, 6'h03};
		tick(3);
		rd(3'h2, 8'h20);
		{rx_fill, tx_fill} <= {6'h04, 6'h02};
		tick(3);
		rd(3'h2, 8'h23);
		pulse(1'b0, 1'b0, 1'b1, 1'b0);
		rd(3'h2, 8'h33);
		tick(2);
		rd(3'h2, 8'h23);
		{tx_idle, modem_pins} <= {1'b0, 4'h2};
		tick(6);
		rd(3'h2, 8'h0b);
		pulse(1'b0, 1'b1, 1'b0, 1'b0);
		rd(3'h2, 8'h03);
		$display("end extended");
		deep32 <= 1'b1;
		tick(3);
		rd(3'h2, 8'h02);
		deep32 <= 1'b0;
		wr(3'h7, 8'h03);
		wr(3'h4, 8'h40);
		modem_pins <= 4'h0;
		tick(6);
		rd(3'h2, 8'h03);
		wr(3'h7, 8'h01);
		tick(1);
		rd(3'h2, 8'h0b);
		pulse(1'b0, 1'b1, 1'b0, 1'b0);
		wr(3'h3, 8'h40);
		tick(1);
		chk({7'h0, ir_out}, 8'h01);
		wr(3'h7, 8'h05);
		run <= 1'b1;
		// Any 32 cycles of a running timer hold exactly two character ticks
		repeat (32) begin
			tick(1);
			n_ir = n_ir + {7'h0, ir_out};
		end
		run <= 1'b0;
		chk(n_ir, 8'h02);
		wr(3'h4, 8'hc0);
		wr(3'h2, 8'h00);
		tick(1);
		chk(format, 8'h00);
		chk({7'h0, queues_enabled}, 8'h01);
		@(posedge clk);
		tx_underrun <= 1'b1;
		@(posedge clk);
		tx_underrun <= 1'b0;
		tick(2);
		rd(3'h2, 8'h05);
		wr(3'h4, 8'h00);
		tick(1);
		rd(3'h2, 8'h01);
		$display("end modes");
		stop_test();
	end
endmodule
